// ---- brs_pkg.sv ----
// package of constants and types for the buck reference sequencer
package brs_pkg;
	// reference and feedback are counted in 12.5 mV units
	localparam int REF_W = 8;
	localparam logic [REF_W-1:0] LEG_TOP = 8'h94; // 1.850 V
	localparam logic [REF_W-1:0] ALT_TOP = 8'h7c; // 1.550 V
	localparam logic [REF_W-1:0] EXT_LOW = 8'h57; // 1.0875 V at code zero
	localparam logic [REF_W-1:0] EXT_WRAP = 8'h95; // 149 minus upper codes
	localparam logic [5:0] EXT_SPLIT = 6'h14;
	localparam logic [5:0] EXT_OFF_LO = 6'h3e;
	localparam logic [REF_W-1:0] OV_FIXED_LEG = 8'h9c; // 1.95 V
	localparam logic [REF_W-1:0] OV_FIXED_ALT = 8'h84; // 1.65 V
	localparam logic [REF_W-1:0] OV_MARGIN = 8'h10; // 200 mV
	localparam logic [REF_W-1:0] OV_HYST = 8'h04; // hysteresis, 50 mV
	// sample and phase-cycle counts
	localparam logic [3:0] SAMPLES_FIVE = 4'h4;
	localparam logic [3:0] SAMPLES_EXT = 4'h6;
	localparam logic [3:0] STABLE_CYCLES = 4'hc;
	localparam logic [1:0] AGREE_READS = 2'h3;
	localparam logic [1:0] STEP_CYCLES_M1 = 2'h3;
	localparam logic [3:0] SS_CYCLES_M1 = 4'hf;
	// register map, byte addresses
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] REF_OFS = 8'h08;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int CTRL_MODE_LSB = 0;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_CLAMP_BIT = 2;
	localparam int STAT_DRV_BIT = 3;
	localparam int STAT_EN_BIT = 4;
	localparam int REF_TGT_LSB = 8;
	typedef enum logic [1:0] {
		MODE_LEGACY = 2'b00,
		MODE_ALT = 2'b01,
		MODE_EXT = 2'b10,
		MODE_RSVD = 2'b11
	} brs_mode_e;
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_DELAY = 2'b01,
		ST_RAMP = 2'b10,
		ST_RUN = 2'b11
	} brs_state_e;
endpackage : brs_pkg

// ---- brs_sequencer.sv ----
// sequencing core of a two-phase buck controller with apb registers
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module brs_sequencer
	import brs_pkg::*;
#(
	parameter int PERIOD_W = 16
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins from outside
	input wire logic phase_clk_i,
	input wire logic [4:0] voltage_id_code_i,
	input wire logic voltage_id_extra_bit_i,
	input wire logic bias_ready_i,
	input wire logic driver_supply_ready_i,
	input wire logic threshold_enable_input_i,
	// digitised feedback, same clock, 12.5 mV units
	input wire logic [REF_W-1:0] feedback_sense_i,
	// drive outputs
	output logic [1:0] low_side_gate_o,
	output logic [1:0] low_side_gate_oe_o,
	output logic drive_enable_o,
	output logic overvoltage_clamp_o,
	output logic [REF_W-1:0] reference_o
);

	// two-flop synchronisers for all pins
	logic [9:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			pin_s1_q <= {phase_clk_i, voltage_id_code_i, voltage_id_extra_bit_i, bias_ready_i,
				driver_supply_ready_i, threshold_enable_input_i};
			pin_s2_q <= pin_s1_q;
		end
	end
	logic phase_s, bias_ok, drv_ok, thr_ok;
	logic [5:0] code_s;
	assign phase_s = pin_s2_q[9];
	assign code_s = {pin_s2_q[8:4], pin_s2_q[3]}; // bit four leads
	assign bias_ok = pin_s2_q[2];
	assign drv_ok = pin_s2_q[1];
	assign thr_ok = pin_s2_q[0];

	// apb registers
	brs_mode_e mode_q, mode_d;
	logic [31:0] rdata_q, rdata_d;
	logic ext, legacy;
	assign ext = (mode_q == MODE_EXT);
	assign legacy = (mode_q == MODE_LEGACY) || (mode_q == MODE_RSVD);

	// core state
	brs_state_e state_q, state_d;
	logic phase_d1_q, phase_tick;
	logic [PERIOD_W-1:0] per_cnt_q, per_cnt_d, period_q, period_d, slice_q, slice_d;
	logic [5:0] cand_q, cand_d, acc_code_q, acc_code_d;
	logic [3:0] stable_q, stable_d, ss_cnt_q, ss_cnt_d;
	logic [1:0] agree_q, agree_d, step_q, step_d;
	logic [REF_W-1:0] ref_q, ref_d;
	logic clamp_q, clamp_d, precharge_q, precharge_d;
	logic sample, accept, code_off, enable_all;
	logic [REF_W-1:0] target, ov_fixed, ov_thr, ov_rel;
	logic [PERIOD_W-1:0] slice_len;

	assign phase_tick = phase_s & ~phase_d1_q;

	// map a code to its reference value
	function automatic logic [REF_W-1:0] code_value(input brs_mode_e m, input logic [5:0] c);
		logic [REF_W-1:0] v;
		v = '0;
		if (m == MODE_EXT) begin
			if (c <= EXT_SPLIT) begin
				v = EXT_LOW - REF_W'(c);
			end else begin
				v = EXT_WRAP - REF_W'(c);
			end
		end else if (m == MODE_ALT) begin
			v = ALT_TOP - REF_W'({c[5:1], 1'b0});
		end else begin
			v = LEG_TOP - REF_W'({c[5:1], 1'b0}); // 25 mV per code
		end
		return v;
	endfunction : code_value

	// off codes, compare against the accepted code
	always_comb begin
		if (ext) begin
			code_off = (acc_code_q >= EXT_OFF_LO);
		end else begin
			code_off = (acc_code_q[5:1] == 5'h1f);
		end
	end

	assign target = code_value(mode_q, acc_code_q);
	assign enable_all = bias_ok & drv_ok & thr_ok & ~code_off;
	assign ov_fixed = legacy ? OV_FIXED_LEG : OV_FIXED_ALT;
	assign ov_rel = ref_q + OV_MARGIN;
	always_comb begin
		if (state_q == ST_RAMP || state_q == ST_DELAY) begin
			ov_thr = (ov_rel > ov_fixed) ? ov_rel : ov_fixed;
		end else if (state_q == ST_RUN) begin
			ov_thr = ov_rel;
		end else begin
			ov_thr = ov_fixed;
		end
	end
	assign slice_len = ext ? period_q / PERIOD_W'(SAMPLES_EXT) : period_q >> 2;

	// sampling, debounce, reference and soft-start next values
	always_comb begin
		per_cnt_d = per_cnt_q + 1'b1;
		period_d = period_q;
		slice_d = slice_q;
		cand_d = cand_q;
		acc_code_d = acc_code_q;
		stable_d = stable_q;
		agree_d = agree_q;
		step_d = step_q;
		ss_cnt_d = ss_cnt_q;
		ref_d = ref_q;
		state_d = state_q;
		precharge_d = precharge_q;
		sample = 1'b0;
		accept = 1'b0;
		if (phase_tick) begin
			period_d = per_cnt_q;
			per_cnt_d = '0;
			slice_d = slice_len;
			sample = 1'b1;
		end else if (slice_q == '0) begin
			slice_d = slice_len;
			sample = 1'b1;
		end else begin
			slice_d = slice_q - 1'b1;
		end
		if (ext) begin
			if (sample) begin
				if ({code_s[5:1], code_s[0]} == cand_q) begin
					if (agree_q != AGREE_READS) begin
						agree_d = agree_q + 1'b1;
					end
				end else begin
					cand_d = code_s;
					agree_d = 2'h1;
				end
			end
			accept = (agree_d == AGREE_READS) && (cand_d != acc_code_q);
		end else begin
			if (sample && (code_s[5:1] != cand_q[5:1])) begin
				cand_d = {code_s[5:1], 1'b0};
				stable_d = '0;
			end else if (phase_tick && stable_q != STABLE_CYCLES) begin
				stable_d = stable_q + 1'b1;
			end
			accept = (stable_d == STABLE_CYCLES) && (cand_d != acc_code_q);
		end
		if (accept) begin
			acc_code_d = cand_d;
			step_d = '0;
		end else if (phase_tick) begin
			step_d = step_q + 1'b1;
		end
		unique case (state_q)
			ST_OFF: begin
				ref_d = '0;
				precharge_d = 1'b0;
				ss_cnt_d = '0;
				if (enable_all) begin
					state_d = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (phase_tick) begin
					ss_cnt_d = ss_cnt_q + 1'b1;
					if (ss_cnt_q == SS_CYCLES_M1) begin
						state_d = ST_RAMP;
					end
				end
			end
			ST_RAMP: begin
				if (ref_q > feedback_sense_i) begin
					precharge_d = 1'b1;
				end
				if (ref_q >= target) begin
					ref_d = target;
					state_d = ST_RUN;
				end else if (phase_tick) begin
					ss_cnt_d = ss_cnt_q + 1'b1;
					if (ss_cnt_q == SS_CYCLES_M1) begin
						ref_d = ref_q + 1'b1;
					end
				end
			end
			ST_RUN: begin
				if (ext) begin
					ref_d = target;
				end else if (phase_tick && step_q == STEP_CYCLES_M1 && !accept) begin
					if (ref_q + 8'h02 <= target) begin
						ref_d = ref_q + 8'h02;
					end else if (ref_q >= target + 8'h02) begin
						ref_d = ref_q - 8'h02;
					end else begin
						ref_d = target;
					end
				end
			end
		endcase
		if (!enable_all) begin
			state_d = ST_OFF;
		end
	end

	// overvoltage clamp with hysteresis, never latched
	always_comb begin
		clamp_d = clamp_q;
		if (!bias_ok) begin
			clamp_d = 1'b0;
		end else if (feedback_sense_i > ov_thr) begin
			clamp_d = 1'b1;
		end else if (feedback_sense_i + OV_HYST < ov_thr) begin
			clamp_d = 1'b0;
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			phase_d1_q <= 1'b0;
			per_cnt_q <= '0;
			period_q <= '0;
			slice_q <= '0;
			cand_q <= 6'h3f;
			acc_code_q <= 6'h3f;
			stable_q <= '0;
			agree_q <= '0;
			step_q <= '0;
			ss_cnt_q <= '0;
			ref_q <= '0;
			state_q <= ST_OFF;
			precharge_q <= 1'b0;
			clamp_q <= 1'b0;
		end else begin
			phase_d1_q <= phase_s;
			per_cnt_q <= per_cnt_d;
			period_q <= period_d;
			slice_q <= slice_d;
			cand_q <= cand_d;
			acc_code_q <= acc_code_d;
			stable_q <= stable_d;
			agree_q <= agree_d;
			step_q <= step_d;
			ss_cnt_q <= ss_cnt_d;
			ref_q <= ref_d;
			state_q <= state_d;
			precharge_q <= precharge_d;
			clamp_q <= clamp_d;
		end
	end

	// outputs
	assign low_side_gate_oe_o = bias_ok ? 2'b11 : 2'b00;
	assign low_side_gate_o = {2{clamp_q}};
	assign overvoltage_clamp_o = clamp_q;
	// enables gate the drivers at once, not a cycle later through the state
	assign drive_enable_o = ~clamp_q & enable_all
		& (state_q == ST_RUN || (state_q == ST_RAMP && precharge_q));
	assign reference_o = ref_q;

	// apb decode: zero wait states, error on unmapped offsets
	logic apb_acc, hit;
	assign apb_acc = psel & penable;
	assign hit = (paddr == CTRL_OFS) || (paddr == STAT_OFS) || (paddr == REF_OFS);
	assign pready = 1'b1;
	assign pslverr = apb_acc & ~hit;
	assign prdata = rdata_q;
	always_comb begin
		mode_d = mode_q;
		rdata_d = rdata_q;
		if (psel && !penable && !pwrite) begin
			rdata_d = '0;
			if (paddr == CTRL_OFS) begin
				rdata_d[CTRL_MODE_LSB +: 2] = mode_q;
			end else if (paddr == STAT_OFS) begin
				rdata_d[STAT_STATE_LSB +: 2] = state_q;
				rdata_d[STAT_CLAMP_BIT] = clamp_q;
				rdata_d[STAT_DRV_BIT] = drive_enable_o;
				rdata_d[STAT_EN_BIT] = enable_all;
			end else if (paddr == REF_OFS) begin
				rdata_d[REF_W-1:0] = ref_q;
				rdata_d[REF_TGT_LSB +: REF_W] = target;
			end
		end
		if (apb_acc && pwrite && paddr == CTRL_OFS) begin
			mode_d = brs_mode_e'(pwdata[CTRL_MODE_LSB +: 2]);
		end
	end
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mode_q <= brs_mode_e'(CTRL_RST);
			rdata_q <= '0;
		end else begin
			mode_q <= mode_d;
			rdata_q <= rdata_d;
		end
	end

	// checks
	sequence s_enable;
		state_q == ST_OFF && enable_all;
	endsequence
	sequence s_delay_end;
		state_q == ST_DELAY && phase_tick && ss_cnt_q == SS_CYCLES_M1 && enable_all;
	endsequence
	a_start_now: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		s_enable |=> state_q == ST_DELAY) else $error("soft-start did not begin");
	a_delay_len: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		s_delay_end |=> state_q == ST_RAMP && ref_q == '0) else $error("ramp delay wrong");
	a_ramp_step: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_q == ST_RAMP && enable_all && ref_q < target && phase_tick && ss_cnt_q == SS_CYCLES_M1
		|=> ref_q == $past(ref_q) + 8'h01) else $error("ramp step wrong");
	a_ext_jump: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_q == ST_RUN && ext && enable_all ##1 state_q == ST_RUN |-> ref_q == $past(target))
		else $error("extended reference did not jump");
	a_leg_accept: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!ext && acc_code_q != $past(acc_code_q) && !$past(ext) |-> $past(stable_d) == STABLE_CYCLES)
		else $error("code accepted early");
	a_gate_float: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!bias_ok |-> low_side_gate_oe_o == 2'b00 && !drive_enable_o ##1 !clamp_q) else $error("drive not floated");
	a_off_code: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		code_off |=> state_q == ST_OFF) else $error("off code did not disable");
	a_clamp_set: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		bias_ok && feedback_sense_i > ov_thr |=> clamp_q && low_side_gate_o == 2'b11) else $error("clamp missed");
	a_clamp_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		clamp_q && bias_ok && feedback_sense_i + OV_HYST >= ov_thr |=> clamp_q) else $error("clamp released early");
	a_precharge: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_q == ST_RAMP && !precharge_q |-> !drive_enable_o) else $error("drivers on above ramp");
	// ramp has passed feedback while still soft-starting
	sequence s_ramp_above;
		state_q == ST_RAMP && enable_all && ref_q > feedback_sense_i;
	endsequence
	a_drive_on: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		s_ramp_above ##1 enable_all && !clamp_q && state_q != ST_OFF |-> drive_enable_o)
		else $error("drivers not enabled above feedback");

endmodule : brs_sequencer

// ---- brs_vid_proc.sv ----
// processor model driving the code pins and the switching clock
`timescale 1ns/1ps
module brs_vid_proc #(
	parameter int HALF = 6
) (
	// clock
	input wire logic clock_i,
	// requests from the bench
	input wire logic ext_i,
	input wire logic [5:0] req_i,
	// pins toward the sequencer
	output logic phase_clk_o,
	output logic [4:0] voltage_id_code_o,
	output logic voltage_id_extra_bit_o
);
	int cnt = 0;
	logic [5:0] cur = 6'h3f;
	// free-running switching clock, code moves on its rising edge
	always @(posedge clock_i) begin
		cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1 && cur != req_i) begin
			if (ext_i && cur[5:1] != 5'h1f) begin
				cur <= (req_i > cur) ? cur + 6'h01 : cur - 6'h01;
			end else begin
				cur <= req_i;
			end
		end
	end
	assign phase_clk_o = (cnt >= HALF);
	// six-bit code split into pins and extra bit
	assign {voltage_id_code_o, voltage_id_extra_bit_o} = cur;
endmodule : brs_vid_proc

// ---- tb_buck_reference_sequencer.sv ----
// self-checking bench for the buck reference sequencer
`timescale 1ns/1ps
module tb_buck_reference_sequencer;
	import brs_pkg::*;
	logic clock_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = '0, fb = '0, ref_v, t;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, err, phase, xbit, de, clamp;
	logic bias = 0, drv = 1, thr = 0, ext = 0, exp_cl = 0;
	logic [4:0] code;
	logic [5:0] req = 6'h3f;
	logic [1:0] gate, gate_oe;
	int miscompares = 0, n_checks = 0, cnt;

	brs_sequencer brs_sequencer_i (.clock_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .phase_clk_i(phase), .voltage_id_code_i(code),
		.voltage_id_extra_bit_i(xbit), .bias_ready_i(bias), .driver_supply_ready_i(drv),
		.threshold_enable_input_i(thr), .feedback_sense_i(fb), .low_side_gate_o(gate),
		.low_side_gate_oe_o(gate_oe), .drive_enable_o(de), .overvoltage_clamp_o(clamp), .reference_o(ref_v));

	brs_vid_proc brs_vid_proc_i (.clock_i, .ext_i(ext), .req_i(req), .phase_clk_o(phase),
		.voltage_id_code_o(code), .voltage_id_extra_bit_o(xbit));

	// 40 MHz clock
	initial begin
		forever #12.5 clock_i = ~clock_i;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask : tick

	// one apb transfer, result left in rd and err
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1;
		do @(posedge clock_i); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	// wait for a reference value, drivers must stay off while below feedback
	task automatic wait_ref(input logic [7:0] v, input logic hold);
		cnt = 0;
		while (ref_v !== v && cnt < 20000) begin
			@(posedge clock_i);
			cnt++;
			if (hold && ref_v <= fb) chk(de, 0, "drive early");
		end
		if (cnt >= 20000) chk(ref_v, v, "ref timeout");
	endtask : wait_ref

	function automatic logic [7:0] ref_of(input logic [1:0] m, input logic [5:0] c);
		if (m == MODE_EXT) return (c <= 6'h14) ? EXT_LOW - c : EXT_WRAP - c;
		return ((m == MODE_ALT) ? ALT_TOP : LEG_TOP) - {2'h0, c[5:1], 1'b0};
	endfunction : ref_of

	// clamp with hysteresis against threshold tt
	task automatic ov(input logic [7:0] f, input logic [7:0] tt);
		fb <= f;
		tick(3);
		if (f > tt) exp_cl = 1;
		else if (f + OV_HYST < tt) exp_cl = 0;
		chk({clamp, gate}, {3{exp_cl}}, "clamp");
	endtask : ov

	// watchdog
	initial begin
		tick(60000);
		miscompares++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		void'($urandom(79));
		tick(6);
		sys_rst_i <= 0;
		chk(gate_oe, 2'h0, "oe no bias");
		apb(0, CTRL_OFS, 0);
		chk(rd, CTRL_RST, "ctrl reset");
		apb(0, 8'h0c, 0);
		chk(err, 1, "unmapped");
		bias <= 1;
		tick(4);
		chk(gate_oe, 2'h3, "oe bias");
		for (int m = 0; m < 3; m++) begin
			apb(1, CTRL_OFS, m);
			apb(0, CTRL_OFS, 0);
			chk(rd, m, "mode");
			t = (m == 0) ? OV_FIXED_LEG : OV_FIXED_ALT;
			ov(t + 1, t);
			ov(t, t);
			ov(t - 5, t);
			ov(t, t);
		end
		// alternate mode start, output pre-charged below target
		apb(1, CTRL_OFS, MODE_ALT);
		req <= 6'h3c;
		fb <= 8'h1e;
		tick(400);
		apb(0, STAT_OFS, 0);
		chk(rd[4:0], 5'h00, "held off");
		thr <= 1;
		tick(4);
		apb(0, STAT_OFS, 0);
		chk(rd[4:0], 5'h11, "delay");
		// fixed threshold still rules while soft-starting at low reference
		ov(8'h85, OV_FIXED_ALT);
		ov(8'h1e, OV_FIXED_ALT);
		wait_ref(1, 1);
		chk(cnt >= 350 && cnt <= 390, 1, "ramp start");
		wait_ref(2, 1);
		chk(cnt, 192, "ramp pace");
		wait_ref(ref_of(MODE_ALT, 6'h3c), 1);
		chk(de, 1, "drive on");
		tick(400);
		apb(0, STAT_OFS, 0);
		chk({rd[3:0], ref_v}, {4'hb, 8'h40}, "run");
		// two-code step in alternate mode
		req <= 6'h38;
		tick(120);
		chk(ref_v, 8'h40, "debounce");
		wait_ref(8'h42, 0);
		wait_ref(ref_of(MODE_ALT, 6'h38), 0);
		chk(cnt, 48, "step pace");
		repeat (8) ov(8'($urandom_range(110, 60)), ref_v + OV_MARGIN);
		ov(8'h28, ref_v + OV_MARGIN);
		chk(de, 1, "not latched");
		// all-ones code parks the controller
		req <= 6'h3e;
		tick(360);
		apb(0, STAT_OFS, 0);
		chk({rd[4:0], de}, 6'h00, "parked");
		// legacy table read back through the target field while held off
		thr <= 0;
		apb(1, CTRL_OFS, MODE_LEGACY);
		req <= {5'($urandom_range(30, 0)), 1'b0};
		tick(200);
		apb(0, REF_OFS, 0);
		chk(rd[15:0], {ref_of(MODE_LEGACY, req), 8'h00}, "legacy table");
		req <= 6'h3e;
		tick(200);
		thr <= 1;
		// extended mode, output pre-charged above target
		apb(1, CTRL_OFS, MODE_EXT);
		ext <= 1;
		fb <= 8'h50;
		req <= 6'h14;
		wait_ref(ref_of(MODE_EXT, 6'h14), 1);
		tick(24);
		chk(de, 1, "drive at end");
		fb <= 8'h3c;
		req <= 6'h13;
		tick(30);
		chk(ref_v, ref_of(MODE_EXT, 6'h13), "ext jump");
		tally_and_finish();
	end
endmodule : tb_buck_reference_sequencer
